// ==== pkg/qed_pkg.sv ====
/*
  qed_pkg: offsets, field positions, reset values and the state record of the
  quadrature encoder decoder.
  Assumes a byte-addressed register port with 32-bit data.
*/
`default_nettype none

package qed_pkg;

    // register byte addresses
    localparam logic [7:0] OFS_CTRL     = 8'h00;
    localparam logic [7:0] OFS_FILTER   = 8'h04;
    localparam logic [7:0] OFS_POSITION = 8'h08;

    // control register fields
    localparam int CTRL_MODE_LSB   = 0;
    localparam int CTRL_SWAP       = 3;
    localparam int CTRL_IDLE_STOP  = 4;
    localparam int CTRL_DIR_OE     = 5;
    localparam int CTRL_IDX_RST_EN = 6;
    localparam int CTRL_ERR_FLAG   = 8;
    localparam int CTRL_DIR_STAT   = 9;

    // filter register fields
    localparam int FLT_PH_DIV_LSB  = 0;
    localparam int FLT_PH_EN       = 3;
    localparam int FLT_IX_DIV_LSB  = 4;
    localparam int FLT_IX_EN       = 7;
    localparam int FLT_ERR_IRQ_DIS = 8;

    // decode mode select values
    localparam logic [2:0] MODE_OFF    = 3'h0;
    localparam logic [2:0] MODE_X2_IDX = 3'h4;
    localparam logic [2:0] MODE_X2     = 3'h5;
    localparam logic [2:0] MODE_X4_IDX = 3'h6;
    localparam logic [2:0] MODE_X4     = 3'h7;

    // values after reset
    localparam logic [2:0]  RST_MODE     = 3'h0;
    localparam logic [2:0]  RST_DIV      = 3'h0;
    localparam logic [15:0] RST_POSITION = 16'h0000;
    localparam logic [7:0]  RST_DIV_CNT  = 8'h00;

    // samples a filter input must hold before the output follows
    localparam int FILTER_SAMPLES = 3;

    typedef struct packed {
        logic [1:0]  sync_a;
        logic [1:0]  sync_b;
        logic [1:0]  sync_i;
        logic [2:0]  hist_a;
        logic [2:0]  hist_b;
        logic [2:0]  hist_i;
        logic        filt_a;
        logic        filt_b;
        logic        filt_i;
        logic        prev_a;
        logic        prev_b;
        logic        prev_i;
        logic [7:0]  div_cnt;
        logic [2:0]  decode_mode_select;
        logic        phase_swap_select;
        logic        idle_stop_select;
        logic        direction_output_enable;
        logic        index_reset_enable;
        logic [2:0]  phase_filter_divide;
        logic        phase_filter_enable;
        logic [2:0]  index_filter_divide;
        logic        index_filter_enable;
        logic        count_error_irq_disable;
        logic        count_error_flag;
        logic        dir_up;
        logic [15:0] position_count;
        logic        irq_index;
        logic        irq_error;
        logic [31:0] rdata;
    } qed_state_s;

endpackage : qed_pkg

`default_nettype wire

// ==== rtl/qed_decoder.sv ====
/*
  qed_decoder: glitch filters, quadrature decoder, 16-bit up/down position
  counter and register port of the quadrature encoder decoder.
  Assumes encoder pins are asynchronous, and that the register master issues
  one-cycle strobes and takes read data in the cycle after the read strobe.
*/
// The register addresses and the strobed register port were decided locally.
`timescale 1ns/1ps
`default_nettype none

module qed_decoder #(
    parameter int POS_W = 16
) (
    // clock and reset
    input  wire logic             CORE_CLK,
    input  wire logic             RESETN,
    // register port
    input  wire logic [7:0]       ADDR,
    input  wire logic [31:0]      WDATA,
    input  wire logic             WR,
    input  wire logic             RD,
    output logic      [31:0]      RDATA,
    // encoder pins
    input  wire logic             PHASE_A_IN,
    input  wire logic             PHASE_B_IN,
    input  wire logic             INDEX_IN,
    // processor idle state
    input  wire logic             IDLE,
    // direction pin
    output logic                  DIR_OUT,
    output logic                  DIR_OE,
    // request pulses
    output logic                  IRQ_INDEX,
    output logic                  IRQ_ERROR,
    // position
    output logic      [POS_W-1:0] POSITION
);

    qed_pkg::qed_state_s st;
    qed_pkg::qed_state_s next_st;

    logic a_raw;
    logic b_raw;
    logic a_eff;
    logic b_eff;
    logic i_eff;
    logic tick_ph;
    logic tick_ix;
    logic run;
    logic x4_mode;
    logic idx_mode;
    logic a_chg;
    logic b_chg;
    logic cnt_step;
    logic cnt_up;
    logic err_evt;
    logic idx_clr;
    logic pos_wr;

    // filter sample enable: one cycle in every 2^(sel+1)
    function automatic logic div_tick(input logic [7:0] cnt, input logic [2:0] sel);
        logic [7:0] mask;
        mask = (8'h02 << sel) - 8'h01;
        return (cnt & mask) == mask;
    endfunction : div_tick

    // shift in a sample; output moves only when all held samples agree
    function automatic logic [3:0] filt_next(input logic [2:0] hist, input logic out,
                                             input logic smp, input logic tick);
        logic [2:0] h;
        logic       o;
        h = hist;
        o = out;
        if (tick)
        begin
            h = {hist[1:0], smp};
            if (h == 3'h7)
                o = 1'b1;
            else if (h == 3'h0)
                o = 1'b0;
        end
        return {h, o};
    endfunction : filt_next

    always_comb
    begin
        next_st = st;
        tick_ph = div_tick(st.div_cnt, st.phase_filter_divide);
        tick_ix = div_tick(st.div_cnt, st.index_filter_divide);
        a_raw = st.phase_filter_enable ? st.filt_a : st.sync_a[1];
        b_raw = st.phase_filter_enable ? st.filt_b : st.sync_b[1];
        i_eff = st.index_filter_enable ? st.filt_i : st.sync_i[1];
        a_eff = st.phase_swap_select ? b_raw : a_raw;
        b_eff = st.phase_swap_select ? a_raw : b_raw;

        x4_mode  = (st.decode_mode_select == qed_pkg::MODE_X4_IDX) ||
                   (st.decode_mode_select == qed_pkg::MODE_X4);
        idx_mode = (st.decode_mode_select == qed_pkg::MODE_X4_IDX) ||
                   (st.decode_mode_select == qed_pkg::MODE_X2_IDX);
        run = (st.decode_mode_select != qed_pkg::MODE_OFF) && !(st.idle_stop_select && IDLE);

        a_chg = a_eff ^ st.prev_a;
        b_chg = b_eff ^ st.prev_b;
        cnt_up = a_eff ^ st.prev_b;
        cnt_step = run && (x4_mode ? (a_chg ^ b_chg) : (a_chg && !b_chg));
        // both phases moving in one sample is a skipped state
        err_evt = run && a_chg && b_chg;
        idx_clr = run && idx_mode && st.index_reset_enable && i_eff && !st.prev_i;
        pos_wr  = WR && (ADDR == qed_pkg::OFS_POSITION);

        // synchronisers: first stage feeds only the second
        next_st.sync_a = {st.sync_a[0], PHASE_A_IN};
        next_st.sync_b = {st.sync_b[0], PHASE_B_IN};
        next_st.sync_i = {st.sync_i[0], INDEX_IN};
        next_st.div_cnt = st.div_cnt + 8'h01;
        {next_st.hist_a, next_st.filt_a} = filt_next(st.hist_a, st.filt_a, st.sync_a[1], tick_ph);
        {next_st.hist_b, next_st.filt_b} = filt_next(st.hist_b, st.filt_b, st.sync_b[1], tick_ph);
        {next_st.hist_i, next_st.filt_i} = filt_next(st.hist_i, st.filt_i, st.sync_i[1], tick_ix);
        next_st.prev_a = a_eff;
        next_st.prev_b = b_eff;
        next_st.prev_i = i_eff;

        if (cnt_step)
        begin
            next_st.dir_up = cnt_up;
            if (cnt_up)
                next_st.position_count = st.position_count + 16'h0001;
            else
                next_st.position_count = st.position_count - 16'h0001;
        end
        if (idx_clr)
            next_st.position_count = qed_pkg::RST_POSITION;
        if (pos_wr)
            next_st.position_count = WDATA[15:0];

        next_st.irq_index = idx_clr;
        next_st.irq_error = err_evt && !st.count_error_irq_disable;

        if (WR && ADDR == qed_pkg::OFS_CTRL)
        begin
            next_st.decode_mode_select      = WDATA[qed_pkg::CTRL_MODE_LSB +: 3];
            next_st.phase_swap_select       = WDATA[qed_pkg::CTRL_SWAP];
            next_st.idle_stop_select        = WDATA[qed_pkg::CTRL_IDLE_STOP];
            next_st.direction_output_enable = WDATA[qed_pkg::CTRL_DIR_OE];
            next_st.index_reset_enable      = WDATA[qed_pkg::CTRL_IDX_RST_EN];
            if (!WDATA[qed_pkg::CTRL_ERR_FLAG])
                next_st.count_error_flag = 1'b0;
        end
        if (WR && ADDR == qed_pkg::OFS_FILTER)
        begin
            next_st.phase_filter_divide     = WDATA[qed_pkg::FLT_PH_DIV_LSB +: 3];
            next_st.phase_filter_enable     = WDATA[qed_pkg::FLT_PH_EN];
            next_st.index_filter_divide     = WDATA[qed_pkg::FLT_IX_DIV_LSB +: 3];
            next_st.index_filter_enable     = WDATA[qed_pkg::FLT_IX_EN];
            next_st.count_error_irq_disable = WDATA[qed_pkg::FLT_ERR_IRQ_DIS];
        end
        // sticky error, set beats a clearing write
        if (err_evt)
            next_st.count_error_flag = 1'b1;

        next_st.rdata = 32'h0000_0000;
        if (RD)
        begin
            case (ADDR)
                qed_pkg::OFS_CTRL:
                begin
                    next_st.rdata[qed_pkg::CTRL_MODE_LSB +: 3]  = st.decode_mode_select;
                    next_st.rdata[qed_pkg::CTRL_SWAP]           = st.phase_swap_select;
                    next_st.rdata[qed_pkg::CTRL_IDLE_STOP]      = st.idle_stop_select;
                    next_st.rdata[qed_pkg::CTRL_DIR_OE]         = st.direction_output_enable;
                    next_st.rdata[qed_pkg::CTRL_IDX_RST_EN]     = st.index_reset_enable;
                    next_st.rdata[qed_pkg::CTRL_ERR_FLAG]       = st.count_error_flag;
                    next_st.rdata[qed_pkg::CTRL_DIR_STAT]       = st.dir_up;
                end
                qed_pkg::OFS_FILTER:
                begin
                    next_st.rdata[qed_pkg::FLT_PH_DIV_LSB +: 3] = st.phase_filter_divide;
                    next_st.rdata[qed_pkg::FLT_PH_EN]           = st.phase_filter_enable;
                    next_st.rdata[qed_pkg::FLT_IX_DIV_LSB +: 3] = st.index_filter_divide;
                    next_st.rdata[qed_pkg::FLT_IX_EN]           = st.index_filter_enable;
                    next_st.rdata[qed_pkg::FLT_ERR_IRQ_DIS]     = st.count_error_irq_disable;
                end
                qed_pkg::OFS_POSITION:
                    next_st.rdata[15:0] = st.position_count;
                default:
                    next_st.rdata = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge CORE_CLK)
    begin
        if (!RESETN)
        begin
            st                    <= '0;
            st.decode_mode_select <= qed_pkg::RST_MODE;
            st.phase_filter_divide <= qed_pkg::RST_DIV;
            st.index_filter_divide <= qed_pkg::RST_DIV;
            st.position_count     <= qed_pkg::RST_POSITION;
            st.div_cnt            <= qed_pkg::RST_DIV_CNT;
        end
        else
            st <= next_st;
    end

    assign RDATA     = st.rdata;
    assign DIR_OUT   = st.dir_up;
    // pin left to general I/O when disabled
    assign DIR_OE    = st.direction_output_enable;
    assign IRQ_INDEX = st.irq_index;
    assign IRQ_ERROR = st.irq_error;
    assign POSITION  = st.position_count;

    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (!RESETN);

    a_count_up_one: assert property (cnt_step && cnt_up && !idx_clr && !pos_wr |=>
        st.position_count == $past(st.position_count) + 16'h0001)
        else $error("forward step did not add one");
    a_count_down_one: assert property (cnt_step && !cnt_up && !idx_clr && !pos_wr |=>
        st.position_count == $past(st.position_count) - 16'h0001)
        else $error("reverse step did not subtract one");
    a_index_clears_count: assert property (idx_clr && !pos_wr |=> st.position_count == 16'h0000 ##1 IRQ_INDEX == 1'b0)
        else $error("index did not clear counter");
    a_index_gate_off: assert property (!st.index_reset_enable |-> !idx_clr)
        else $error("index cleared with reset disabled");
    a_mode_off_still: assert property (st.decode_mode_select == qed_pkg::MODE_OFF && !pos_wr |=>
        $stable(st.position_count))
        else $error("counter moved while decoder off");
    a_x2_edge_a: assert property (cnt_step && !x4_mode |-> a_chg && !b_chg)
        else $error("x2 counted without an A edge");
    a_error_sticky: assert property (err_evt |=> st.count_error_flag ##1 (st.count_error_flag ||
        $past(WR && ADDR == qed_pkg::OFS_CTRL && !WDATA[qed_pkg::CTRL_ERR_FLAG])))
        else $error("count error flag not held");
    a_error_irq_gate: assert property (err_evt |=> IRQ_ERROR == !$past(st.count_error_irq_disable))
        else $error("error request not gated correctly");
    a_filter_three: assert property ($rose(st.filt_a) |-> $past(st.hist_a) != 3'h7 && st.hist_a == 3'h7)
        else $error("filter rose without three samples");
    a_sw_preset: assert property (pos_wr |=> st.position_count == $past(WDATA[15:0]))
        else $error("position preset lost");

    c_forward_run: cover property (cnt_step && cnt_up ##[1:200] cnt_step && cnt_up);
    c_reverse_run: cover property (cnt_step && !cnt_up ##[1:200] cnt_step && !cnt_up);
    c_index_reset: cover property (x4_mode && idx_clr);
    c_count_error: cover property (err_evt && st.count_error_irq_disable);

endmodule : qed_decoder

`default_nettype wire

// ==== verif/qed_encoder_model.sv ====
/*
  qed_encoder_model: incremental encoder with index output, stepped by the bench.
  Assumes the bench spaces its step commands wider than the decoder's filter window.
*/
`timescale 1ns/1ps
`default_nettype none

module qed_encoder_model (
    // clock and reset
    input  wire logic       clk,
    input  wire logic       rst_n,
    // step command: 1 forward, 2 reverse, 3 both phases at once (fault)
    input  wire logic       go,
    input  wire logic [1:0] cmd,
    input  wire logic       idx,
    // encoder pins, push-pull so always driven
    output logic            phase_a,
    output logic            phase_b,
    output logic            index
);
    logic [1:0] pos;

    assign phase_a = pos[1] ^ pos[0];
    assign phase_b = pos[1];
    assign index   = idx;

    always_ff @(posedge clk)
    begin
        if (!rst_n)
            pos <= 2'h0;
        else if (go)
            pos <= pos + ((cmd == 2'h1) ? 2'h1 : (cmd == 2'h2) ? 2'h3 : 2'h2);
    end
endmodule : qed_encoder_model

`default_nettype wire

// ==== verif/qed_decoder_tb.sv ====
/*
  qed_decoder_tb: directed scenarios for the quadrature decoder.
  Assumes the encoder model on the pins and the bench as register master.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin n_mismatch++; $display("BAD %0t got %0h exp %0h", $time, g, e); end end

module qed_decoder_tb;
    logic        clk, rst_n, wr, rd, idle, go, idx;
    logic        ph_a, ph_b, ph_i, dir_out, dir_oe, irq_ix, irq_er;
    logic [1:0]  cmd;
    logic [7:0]  addr;
    logic [31:0] wdata, rdata, rdv;
    logic [15:0] pos;
    int          n_mismatch, cmp_count, n_irq_ix, n_irq_er;

    qed_decoder i_dut (.CORE_CLK(clk), .RESETN(rst_n), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
        .RDATA(rdata), .PHASE_A_IN(ph_a), .PHASE_B_IN(ph_b), .INDEX_IN(ph_i), .IDLE(idle),
        .DIR_OUT(dir_out), .DIR_OE(dir_oe), .IRQ_INDEX(irq_ix), .IRQ_ERROR(irq_er), .POSITION(pos));
    qed_encoder_model i_enc (.clk(clk), .rst_n(rst_n), .go(go), .cmd(cmd), .idx(idx),
        .phase_a(ph_a), .phase_b(ph_b), .index(ph_i));

    always #10 clk = ~clk;

    // request pulses last one cycle, so count them as they pass
    always @(posedge clk)
    begin
        if (irq_ix === 1'b1) n_irq_ix++;
        if (irq_er === 1'b1) n_irq_er++;
    end

    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask : wr_reg

    task automatic rd_reg(input logic [7:0] a);
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 rdv = rdata;
    endtask : rd_reg

    task automatic step(input logic [1:0] c, input int n);
        @(posedge clk);
        cmd <= c;
        go  <= 1'b1;
        @(posedge clk);
        go <= 1'b0;
        repeat (n) @(posedge clk);
    endtask : step

    task automatic pulse_idx(input int w);
        @(posedge clk);
        idx <= 1'b1;
        repeat (w) @(posedge clk);
        idx <= 1'b0;
        repeat (8) @(posedge clk);
    endtask : pulse_idx

    task automatic t_reset;
        wr_reg(8'h0C, 32'hFFFF_FFFF);
        rd_reg(8'h0C);
        `CHK(rdv, 32'h0)
        rd_reg(8'h00);
        `CHK(rdv, 32'h0)
        @(posedge clk);
        #1 `CHK(rdata, 32'h0)
        rd_reg(8'h04);
        `CHK(rdv, 32'h0)
        `CHK(dir_oe, 1'b0)
    endtask : t_reset

    task automatic t_preset;
        wr_reg(8'h08, 32'h1234);
        rd_reg(8'h08);
        `CHK(rdv, 32'h0000_1234)
        step(2'h1, 8);
        `CHK(pos, 16'h1234)
    endtask : t_preset

    task automatic t_x4;
        wr_reg(8'h08, 32'hFFFE);
        wr_reg(8'h00, 32'h27);
        idle <= 1'b1;
        repeat (4) step(2'h1, 8);
        `CHK(pos, 16'h0002)
        `CHK(dir_out, 1'b1)
        `CHK(dir_oe, 1'b1)
        repeat (4) step(2'h2, 8);
        `CHK(pos, 16'hFFFE)
        `CHK(dir_out, 1'b0)
        // idle stop selected while idle: counting must halt
        wr_reg(8'h00, 32'h37);
        step(2'h1, 8);
        `CHK(pos, 16'hFFFE)
        idle <= 1'b0;
        step(2'h2, 8);
        `CHK(pos, 16'hFFFD)
    endtask : t_x4

    task automatic t_x2;
        for (int m = 4; m < 6; m++)
        begin
            wr_reg(8'h08, 32'h0);
            wr_reg(8'h00, 32'(m));
            repeat (4) step(2'h1, 8);
            `CHK(pos, 16'h0002)
        end
    endtask : t_x2

    task automatic t_swap;
        // swap only while the decoder is off, else both phases jump at once
        wr_reg(8'h00, 32'h08);
        wr_reg(8'h08, 32'h0);
        wr_reg(8'h00, 32'h0F);
        repeat (2) step(2'h1, 8);
        `CHK(pos, 16'hFFFE)
        wr_reg(8'h00, 32'h08);
        wr_reg(8'h00, 32'h00);
    endtask : t_swap

    task automatic t_err;
        int e;
        e = n_irq_er;
        wr_reg(8'h08, 32'h40);
        wr_reg(8'h00, 32'h07);
        step(2'h3, 8);
        rd_reg(8'h00);
        `CHK(rdv[8], 1'b1)
        `CHK(pos, 16'h0040)
        `CHK(n_irq_er, e + 1)
        wr_reg(8'h00, 32'h07);
        rd_reg(8'h00);
        `CHK(rdv[8], 1'b0)
        wr_reg(8'h04, 32'h100);
        step(2'h3, 8);
        rd_reg(8'h00);
        `CHK(rdv[8], 1'b1)
        `CHK(n_irq_er, e + 1)
        wr_reg(8'h04, 32'h0);
        wr_reg(8'h00, 32'h07);
    endtask : t_err

    task automatic t_index;
        int e;
        e = n_irq_ix;
        wr_reg(8'h00, 32'h46);
        wr_reg(8'h08, 32'h55);
        pulse_idx(4);
        `CHK(pos, 16'h0000)
        `CHK(n_irq_ix, e + 1)
        wr_reg(8'h00, 32'h06);
        wr_reg(8'h08, 32'h55);
        pulse_idx(4);
        `CHK(pos, 16'h0055)
        wr_reg(8'h00, 32'h47);
        pulse_idx(4);
        `CHK(pos, 16'h0055)
        // 100 cycles spans at most two samples at 1:64
        wr_reg(8'h04, 32'hD0);
        wr_reg(8'h00, 32'h46);
        pulse_idx(100);
        `CHK(pos, 16'h0055)
        pulse_idx(400);
        `CHK(pos, 16'h0000)
    endtask : t_index

    task automatic t_filter;
        wr_reg(8'h04, 32'h0D);
        repeat (400) @(posedge clk);
        wr_reg(8'h08, 32'h10);
        step(2'h1, 100);
        `CHK(pos, 16'h0010)
        step(2'h2, 400);
        `CHK(pos, 16'h0010)
        step(2'h1, 8);
        `CHK(pos, 16'h0010)
        repeat (400) @(posedge clk);
        `CHK(pos, 16'h0011)
    endtask : t_filter

    task automatic close_out;
        $display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
        if (n_mismatch == 0 && cmp_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : close_out

    initial
    begin
        repeat (20000) @(posedge clk);
        n_mismatch++;
        close_out();
    end

    initial
    begin
        {clk, rst_n, wr, rd, idle, go, idx, cmd, addr, wdata} = '0;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        t_reset();
        t_preset();
        t_x4();
        t_x2();
        t_swap();
        t_err();
        t_index();
        t_filter();
        close_out();
    end
endmodule : qed_decoder_tb

`default_nettype wire
